// File: verilog/hwtc_regs.v
// Waveform timing offset, voltage reference and calibration register bank of the playback engine.
`timescale 1ns/1ps
// Overview of operation
// - Negative sustain time changes by sustain offset times sample_period_unit, in ms.
// - Every negative sample outside the overdrive and braking segments counts as negative sustain.
// - Both time offset codes are signed two's complement; negative removes time.
// - Brake segment time changes by brake offset times sample_period_unit, in ms.
// - The most negative waveform sample is taken as the braking segment.
// - Brake offset applies only in open loop; closed loop brakes automatically.
// - Rated voltage register, reset 63, is the closed-loop full-scale reference.
// - Closed-loop overdrive and braking may exceed rated voltage, limited by clamp 137.
// - Compensation register, reset 13, stores calibration result offsetting resistive losses.
// - Calibration measures impedance and derives the compensation value itself.
// - Feedback gain derives from back-EMF calibration register, reset 109.
`include "hwtc_consts.vh"
module hwtc_regs #(
	parameter INTERVAL_W = `HWTC_INTERVAL_W
) (
	input  wire                                clk_sys_i,
	input  wire                                srst_i,
	input  wire        [7:0]                   reg_addr_i,
	input  wire                                reg_wr_i,
	input  wire        [7:0]                   reg_wdata_i,
	input  wire                                reg_rd_i,
	output reg         [7:0]                   reg_rdata_o,
	output reg                                 reg_rvalid_o,
	input  wire                                cal_done_i,
	input  wire        [7:0]                   cal_comp_i,
	input  wire        [7:0]                   cal_bemf_i,
	input  wire signed [7:0]                   sample_i,
	input  wire signed [7:0]                   wave_max_i,
	input  wire signed [7:0]                   wave_min_i,
	input  wire                                closed_loop_i,
	input  wire        [INTERVAL_W-1:0]        sample_period_unit_i,
	input  wire        [7:0]                   drive_level_i,
	input  wire                                auto_boost_i,
	output reg                                 neg_sustain_o,
	output reg                                 brake_o,
	output reg  signed [`HWTC_OFFSET_MS_W-1:0] offset_ms_o,
	output reg         [7:0]                   drive_limited_o,
	output reg         [7:0]                   full_scale_ref_o,
	output reg         [7:0]                   loss_comp_o,
	output reg         [7:0]                   feedback_gain_o
);

	reg  [7:0] negative_sustain_offset_reg;
	reg  [7:0] negative_sustain_offset_next;
	reg  [7:0] brake_duration_offset_reg;
	reg  [7:0] brake_duration_offset_next;
	reg  [7:0] full_scale_reference_voltage_reg;
	reg  [7:0] full_scale_reference_voltage_next;
	reg  [7:0] overdrive_voltage_limit_reg;
	reg  [7:0] overdrive_voltage_limit_next;
	reg  [7:0] resistive_loss_compensation_reg;
	reg  [7:0] resistive_loss_compensation_next;
	reg  [7:0] feedback_gain_calibration_reg;
	reg  [7:0] feedback_gain_calibration_next;
	reg  [7:0] rdata_next;
	reg  [7:0] limit_next;
	wire       seg_neg;
	wire       seg_brake;
	wire signed [`HWTC_OFFSET_MS_W-1:0] seg_offset;

	// Slot numbers of the six mapped registers; every other address decodes to the unmapped slot.
	localparam [2:0] SLOT_NEG_SUSTAIN = 3'h0;
	localparam [2:0] SLOT_BRAKE_TIME  = 3'h1;
	localparam [2:0] SLOT_FULL_SCALE  = 3'h2;
	localparam [2:0] SLOT_OD_LIMIT    = 3'h3;
	localparam [2:0] SLOT_LOSS_COMP   = 3'h4;
	localparam [2:0] SLOT_FB_GAIN     = 3'h5;
	localparam [2:0] SLOT_NONE        = 3'h7;

	// Address decode shared by the write path and the read mux, so the two can never disagree.
	function [2:0] addr_slot;
		input [7:0] addr;
		begin
			case (addr)
				`HWTC_ADDR_NEG_SUSTAIN: addr_slot = SLOT_NEG_SUSTAIN;
				`HWTC_ADDR_BRAKE_TIME:  addr_slot = SLOT_BRAKE_TIME;
				`HWTC_ADDR_FULL_SCALE:  addr_slot = SLOT_FULL_SCALE;
				`HWTC_ADDR_OD_LIMIT:    addr_slot = SLOT_OD_LIMIT;
				`HWTC_ADDR_LOSS_COMP:   addr_slot = SLOT_LOSS_COMP;
				`HWTC_ADDR_FB_GAIN:     addr_slot = SLOT_FB_GAIN;
				default:                addr_slot = SLOT_NONE;
			endcase
		end
	endfunction

	// Clip a drive request to a ceiling; used for both the rated and the overdrive ceiling.
	function [7:0] clip;
		input [7:0] level;
		input [7:0] ceiling;
		begin
			clip = (level > ceiling) ? ceiling : level;
		end
	endfunction

	// Host writes land by address; the calibration result overrides a host write in the same cycle.
	always @* begin
		negative_sustain_offset_next      = negative_sustain_offset_reg;
		brake_duration_offset_next        = brake_duration_offset_reg;
		full_scale_reference_voltage_next = full_scale_reference_voltage_reg;
		overdrive_voltage_limit_next      = overdrive_voltage_limit_reg;
		resistive_loss_compensation_next  = resistive_loss_compensation_reg;
		feedback_gain_calibration_next    = feedback_gain_calibration_reg;
		if (reg_wr_i) begin
			case (addr_slot(reg_addr_i))
				SLOT_NEG_SUSTAIN: negative_sustain_offset_next      = reg_wdata_i;
				SLOT_BRAKE_TIME:  brake_duration_offset_next        = reg_wdata_i;
				SLOT_FULL_SCALE:  full_scale_reference_voltage_next = reg_wdata_i;
				SLOT_OD_LIMIT:    overdrive_voltage_limit_next      = reg_wdata_i;
				SLOT_LOSS_COMP:   resistive_loss_compensation_next  = reg_wdata_i;
				SLOT_FB_GAIN:     feedback_gain_calibration_next    = reg_wdata_i;
				default: begin
				end
			endcase
		end
		if (cal_done_i) begin
			resistive_loss_compensation_next = cal_comp_i;
			feedback_gain_calibration_next   = cal_bemf_i;
		end
	end

	// Read mux; the gap at 0x1E and any other address read as zero.
	always @* begin
		case (addr_slot(reg_addr_i))
			SLOT_NEG_SUSTAIN:       rdata_next = negative_sustain_offset_reg;
			SLOT_BRAKE_TIME:        rdata_next = brake_duration_offset_reg;
			SLOT_FULL_SCALE:        rdata_next = full_scale_reference_voltage_reg;
			SLOT_OD_LIMIT:          rdata_next = overdrive_voltage_limit_reg;
			SLOT_LOSS_COMP:         rdata_next = resistive_loss_compensation_reg;
			SLOT_FB_GAIN:           rdata_next = feedback_gain_calibration_reg;
			default:                rdata_next = `HWTC_RD_UNMAPPED;
		endcase
	end

	// Output ceiling: rated voltage in closed loop, the overdrive limit in closed-loop boost phases, none in open loop.
	always @* begin
		if (closed_loop_i && auto_boost_i) begin
			limit_next = clip(drive_level_i, overdrive_voltage_limit_reg);
		end else if (closed_loop_i) begin
			limit_next = clip(drive_level_i, full_scale_reference_voltage_reg);
		end else begin
			limit_next = drive_level_i;
		end
	end

	// Segment classification and offset scaling sit in their own combinational block.
	hwtc_seg_sel u_seg_sel (
		.sample_i                (sample_i),
		.wave_max_i              (wave_max_i),
		.wave_min_i              (wave_min_i),
		.closed_loop_i           (closed_loop_i),
		.interval_ms_i           (sample_period_unit_i[`HWTC_INTERVAL_W-1:0]),
		.neg_sustain_offset_i    (negative_sustain_offset_reg),
		.brake_duration_offset_i (brake_duration_offset_reg),
		.neg_sustain_o           (seg_neg),
		.brake_o                 (seg_brake),
		.offset_ms_o             (seg_offset)
	);

	// Register state; a reset brings back the power-up defaults of the whole bank.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			negative_sustain_offset_reg      <= `HWTC_RST_NEG_SUSTAIN;
			brake_duration_offset_reg        <= `HWTC_RST_BRAKE_TIME;
			full_scale_reference_voltage_reg <= `HWTC_RST_FULL_SCALE;
			overdrive_voltage_limit_reg      <= `HWTC_RST_OD_LIMIT;
			resistive_loss_compensation_reg  <= `HWTC_RST_LOSS_COMP;
			feedback_gain_calibration_reg    <= `HWTC_RST_FB_GAIN;
		end else begin
			negative_sustain_offset_reg      <= negative_sustain_offset_next;
			brake_duration_offset_reg        <= brake_duration_offset_next;
			full_scale_reference_voltage_reg <= full_scale_reference_voltage_next;
			overdrive_voltage_limit_reg      <= overdrive_voltage_limit_next;
			resistive_loss_compensation_reg  <= resistive_loss_compensation_next;
			feedback_gain_calibration_reg    <= feedback_gain_calibration_next;
		end
	end

	// Read response; the data stays put between reads so a slow host can still pick it up.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			reg_rdata_o  <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= rdata_next;
			end
		end
	end

	// Segment and drive outputs; one cycle of latency keeps every output straight from a flop.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			neg_sustain_o   <= 1'b0;
			brake_o         <= 1'b0;
			offset_ms_o     <= {`HWTC_OFFSET_MS_W{1'b0}};
			drive_limited_o <= 8'h00;
		end else begin
			neg_sustain_o   <= seg_neg;
			brake_o         <= seg_brake;
			offset_ms_o     <= seg_offset;
			drive_limited_o <= limit_next;
		end
	end

	// Reference copies for the loop; they trail their registers by one cycle.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			full_scale_ref_o <= `HWTC_RST_FULL_SCALE;
			loss_comp_o      <= `HWTC_RST_LOSS_COMP;
			feedback_gain_o  <= `HWTC_RST_FB_GAIN;
		end else begin
			full_scale_ref_o <= full_scale_reference_voltage_reg;
			loss_comp_o      <= resistive_loss_compensation_reg;
			feedback_gain_o  <= feedback_gain_calibration_reg;
		end
	end

endmodule // hwtc_regs

// File: verilog/hwtc_consts.vh
// Register offsets, reset values and widths of the waveform timing and calibration bank.
`ifndef HWTC_CONSTS_VH
`define HWTC_CONSTS_VH

`define HWTC_ADDR_NEG_SUSTAIN   8'h1C
`define HWTC_ADDR_BRAKE_TIME    8'h1D
`define HWTC_ADDR_FULL_SCALE    8'h1F
`define HWTC_ADDR_OD_LIMIT      8'h20
`define HWTC_ADDR_LOSS_COMP     8'h21
`define HWTC_ADDR_FB_GAIN       8'h22

`define HWTC_RST_NEG_SUSTAIN    8'h00
`define HWTC_RST_BRAKE_TIME     8'h00
`define HWTC_RST_FULL_SCALE     8'h3F
`define HWTC_RST_OD_LIMIT       8'h89
`define HWTC_RST_LOSS_COMP      8'h0D
`define HWTC_RST_FB_GAIN        8'h6D

`define HWTC_RD_UNMAPPED        8'h00
`define HWTC_INTERVAL_W         4
`define HWTC_OFFSET_MS_W        13

`endif

// File: verilog/hwtc_seg_sel.v
// Waveform segment classifier that picks the time offset applying to one library sample.
`timescale 1ns/1ps
`include "hwtc_consts.vh"
module hwtc_seg_sel (
	input  wire signed [7:0]                     sample_i,
	input  wire signed [7:0]                     wave_max_i,
	input  wire signed [7:0]                     wave_min_i,
	input  wire                                  closed_loop_i,
	input  wire        [`HWTC_INTERVAL_W-1:0]    interval_ms_i,
	input  wire        [7:0]                     neg_sustain_offset_i,
	input  wire        [7:0]                     brake_duration_offset_i,
	output reg                                   neg_sustain_o,
	output reg                                   brake_o,
	output reg  signed [`HWTC_OFFSET_MS_W-1:0]   offset_ms_o
);

	// Signed offset times unsigned interval; the interval is zero-extended so the product stays signed.
	function signed [`HWTC_OFFSET_MS_W-1:0] scale_ms;
		input [7:0]                    code;
		input [`HWTC_INTERVAL_W-1:0]   ivl;
		reg signed [`HWTC_OFFSET_MS_W-1:0] c;
		reg signed [`HWTC_OFFSET_MS_W-1:0] m;
		begin
			c        = {{(`HWTC_OFFSET_MS_W-8){code[7]}}, code};
			m        = {{(`HWTC_OFFSET_MS_W-`HWTC_INTERVAL_W){1'b0}}, ivl};
			scale_ms = c * m;
		end
	endfunction

	// The brake segment takes precedence over sustain because the most negative sample is also negative.
	always @* begin
		neg_sustain_o = 1'b0;
		brake_o       = 1'b0;
		offset_ms_o   = {`HWTC_OFFSET_MS_W{1'b0}};
		if (sample_i < 0 && sample_i == wave_min_i) begin
			brake_o = 1'b1;
			if (!closed_loop_i) begin
				offset_ms_o = scale_ms(brake_duration_offset_i, interval_ms_i);
			end
		end else if (sample_i < 0 && sample_i != wave_max_i) begin
			neg_sustain_o = 1'b1;
			offset_ms_o   = scale_ms(neg_sustain_offset_i, interval_ms_i);
		end
	end

endmodule // hwtc_seg_sel

// File: verification/hwtc_regs_chk.sv
// Concurrent checks on the ports of the timing offset and calibration register bank.
`timescale 1ns/1ps
`include "hwtc_consts.vh"
module hwtc_chk (
	input wire                                clk_sys_i,
	input wire                                srst_i,
	input wire                                reg_rd_i,
	input wire                                cal_done_i,
	input wire        [7:0]                   cal_comp_i,
	input wire        [7:0]                   cal_bemf_i,
	input wire signed [7:0]                   sample_i,
	input wire signed [7:0]                   wave_min_i,
	input wire                                closed_loop_i,
	input wire        [7:0]                   drive_level_i,
	input wire                                reg_rvalid_o,
	input wire                                neg_sustain_o,
	input wire                                brake_o,
	input wire signed [`HWTC_OFFSET_MS_W-1:0] offset_ms_o,
	input wire        [7:0]                   drive_limited_o,
	input wire        [7:0]                   full_scale_ref_o,
	input wire        [7:0]                   loss_comp_o,
	input wire        [7:0]                   feedback_gain_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// A calibration pulse, and the most negative sample arriving in closed loop.
	sequence s_cal; cal_done_i; endsequence
	sequence s_brk_cl; closed_loop_i && sample_i < 0 && sample_i == wave_min_i; endsequence
	// Outputs are tied to their causes with exact latencies, so an off-by-one slip shows up.
	a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
	a_no_stray: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
	a_reset_defaults: assert property ($fell(srst_i) |-> full_scale_ref_o == 8'h3F
		&& loss_comp_o == 8'h0D && feedback_gain_o == 8'h6D) else $error("wrong defaults after reset");
	a_cal_comp: assert property (s_cal |=> ##1 loss_comp_o == $past(cal_comp_i, 2)) else $error("comp not loaded");
	a_cal_gain: assert property (s_cal |=> ##1 feedback_gain_o == $past(cal_bemf_i, 2)) else $error("gain not loaded");
	a_closed_brake: assert property (s_brk_cl |=> brake_o && offset_ms_o == 0) else $error("closed brake offset");
	a_positive_idle: assert property (sample_i >= 0 |=> !brake_o && !neg_sustain_o) else $error("positive flagged");
	a_open_pass: assert property (!closed_loop_i |=> drive_limited_o == $past(drive_level_i)) else $error("open clamped");
endmodule // hwtc_chk

bind hwtc_regs hwtc_chk u_chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_rd_i(reg_rd_i), .cal_done_i(cal_done_i),
	.cal_comp_i(cal_comp_i), .cal_bemf_i(cal_bemf_i), .sample_i(sample_i), .wave_min_i(wave_min_i),
	.closed_loop_i(closed_loop_i), .drive_level_i(drive_level_i), .reg_rvalid_o(reg_rvalid_o), .brake_o(brake_o),
	.neg_sustain_o(neg_sustain_o), .offset_ms_o(offset_ms_o), .drive_limited_o(drive_limited_o),
	.full_scale_ref_o(full_scale_ref_o), .loss_comp_o(loss_comp_o), .feedback_gain_o(feedback_gain_o));

// File: verification/hwtc_host.sv
// Host model that issues single-byte register reads and writes to the bank.
`timescale 1ns/1ps
module hwtc_host (
	input  wire       clk_sys_i,
	input  wire [7:0] reg_rdata_i,
	input  wire       reg_rvalid_i,
	output reg  [7:0] reg_addr_o = 8'h00,
	output reg        reg_wr_o = 1'b0,
	output reg  [7:0] reg_wdata_o = 8'h00,
	output reg        reg_rd_o = 1'b0
);
	// One access per call; released address and data lines carry the inverse so stale values never pass for a request.
	task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q, output v);
		@(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= w;
		reg_rd_o <= !w;
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
		@(posedge clk_sys_i);
		q = reg_rdata_i;
		v = reg_rvalid_i;
	endtask
endmodule // hwtc_host

// File: verification/tb.sv
// Self-checking bench of the timing offset and calibration register bank.
`timescale 1ns/1ps
module tb;
	reg                clk_sys_i = 1'b0;
	reg                srst_i = 1'b1;
	reg                cal_i = 1'b0;
	reg                v;
	reg         [31:0] s = 32'h00000000;
	reg         [31:0] r;
	reg         [7:0]  q, i, k;
	reg         [7:0]  model [0:6];
	wire        [7:0]  addr, wdata, rdata, lim, fs, comp, gain;
	wire               wr, rd, rv, sus, brk;
	wire signed [12:0] ofs;
	wire signed [7:0]  mn = {1'b1, s[6:0]};
	wire signed [7:0]  smp = s[17:16] == 2'h0 ? mn : (s[17:16] == 2'h1 ? s[15:8] : s[31:24]);
	integer            errors = 0;
	integer            samples_checked = 0;
	integer            o;
	// The host owns the bus; waveform and calibration inputs come from the random word s.
	hwtc_host host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_rvalid_i(rv), .reg_addr_o(addr), .reg_wr_o(wr),
		.reg_wdata_o(wdata), .reg_rd_o(rd));
	hwtc_regs uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rv), .cal_done_i(cal_i), .cal_comp_i(s[7:0]),
		.cal_bemf_i(s[15:8]), .sample_i(smp), .wave_max_i(s[15:8]), .wave_min_i(mn), .closed_loop_i(s[18]),
		.sample_period_unit_i(s[23:20]), .drive_level_i(s[31:24]), .auto_boost_i(s[19]), .neg_sustain_o(sus),
		.brake_o(brk), .offset_ms_o(ofs), .drive_limited_o(lim), .full_scale_ref_o(fs), .loss_comp_o(comp),
		.feedback_gain_o(gain));
	// Expected brake, sustain and offset; the minimum is tested first so it never counts as sustain.
	function [14:0] seg_exp(input signed [7:0] sm, input signed [7:0] mi, input signed [7:0] mx, input cl, input [3:0] u);
		o = $signed(sm == mi ? model[1] : model[0]) * $signed({1'b0, u});
		if (sm < 0 && sm == mi) seg_exp = {2'h2, cl ? 13'h0000 : o[12:0]};
		else if (sm < 0 && sm != mx) seg_exp = {2'h1, o[12:0]};
		else seg_exp = 15'h0000;
	endfunction
	// Closed loop caps at the clamp during boost and at the rated voltage otherwise.
	function [7:0] lim_exp(input cl, input b, input [7:0] d);
		lim_exp = !cl ? d : (b ? (d > model[4] ? model[4] : d) : (d > model[3] ? model[3] : d));
	endfunction
	// Compares one value and counts it.
	task chk(input [31:0] e, input [31:0] g, input [63:0] n);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("mismatch %0s expected %h seen %h", n, e, g);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task give_verdict;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always #12.5 clk_sys_i = ~clk_sys_i;
	// Passes 0 to 6 read defaults, passes 7 to 34 except 28 write random bytes, pass 28 follows calibration; 0x1E is a hole.
	initial begin
		r = $urandom(10);
		{model[0], model[1], model[2], model[3], model[4], model[5], model[6]} = 56'h0000003F890D6D;
		repeat (6) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		for (i = 8'h00; i < 8'h23; i = i + 8'h01) begin
			k = i % 8'h07;
			r = $urandom;
			if (i == 8'h1C) begin
				host.xfer(1'b1, 8'h1F, 8'h50, q, v);
				model[3] = 8'h50;
				s <= r;
				cal_i <= 1'b1;
				@(posedge clk_sys_i);
				cal_i <= 1'b0;
				model[5] = r[7:0];
				model[6] = r[15:8];
			end else if (i > 8'h06) begin
				host.xfer(1'b1, 8'h1C + k, r[7:0], q, v);
				if (k != 8'h02) model[k] = r[7:0];
			end
			host.xfer(1'b0, 8'h1C + k, 8'h00, q, v);
			chk(32'h00000001, {31'h00000000, v}, "rvalid");
			chk({24'h000000, model[k]}, {24'h000000, q}, "rdata");
			chk({8'h00, model[3], model[5], model[6]}, {8'h00, fs, comp, gain}, "refs");
		end
		// A quarter of the samples take the waveform minimum and a quarter the maximum.
		for (i = 8'h00; i < 8'hC8; i = i + 8'h01) begin
			@(posedge clk_sys_i);
			s <= $urandom;
			@(posedge clk_sys_i);
			#1;
			chk({17'h0, seg_exp(smp, mn, s[15:8], s[18], s[23:20])}, {17'h0, brk, sus, ofs}, "seg");
			chk({24'h0, lim_exp(s[18], s[19], s[31:24])}, {24'h0, lim}, "limit");
		end
		// A second reset in mid-run must return every register and reference copy to its default.
		@(posedge clk_sys_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		{model[0], model[1], model[2], model[3], model[4], model[5], model[6]} = 56'h0000003F890D6D;
		for (i = 8'h00; i < 8'h07; i = i + 8'h01) begin
			host.xfer(1'b0, 8'h1C + i, 8'h00, q, v);
			chk({24'h000000, model[i]}, {24'h000000, q}, "rdata");
			chk({8'h00, model[3], model[5], model[6]}, {8'h00, fs, comp, gain}, "refs");
		end
		give_verdict;
	end
endmodule // tb
